// *** include/ppc_pkg.sv ***
// Constants, register indices and state encoding for the packet control and status registers
package ppc_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int IDX_W = 10;
    localparam int EVT_W = 8;

    // Register indices; the byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_RX_FRAME_STATUS = 10'h01f;
    localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE_0 = 10'h100;
    localparam logic [IDX_W-1:0] IDX_TX_RING_WATERMARK = 10'h136;
    localparam logic [IDX_W-1:0] IDX_TX_RING_LENGTH = 10'h137;
    localparam logic [IDX_W-1:0] IDX_LEVEL_SETTLE_DELAY = 10'h138;
    localparam logic [IDX_W-1:0] IDX_TEST_MODE_CTRL = 10'h139;
    localparam logic [IDX_W-1:0] IDX_TRANSITION_SPEED = 10'h13a;
    localparam logic [IDX_W-1:0] IDX_OSC_BAND_CAL = 10'h13b;
    localparam logic [IDX_W-1:0] IDX_OSC_AMPLITUDE_CAL = 10'h13c;
    localparam logic [IDX_W-1:0] IDX_TX_RING_START = 10'h140;
    localparam logic [IDX_W-1:0] IDX_ASSESS_RESULT = 10'h141;
    localparam logic [IDX_W-1:0] IDX_IRQ_SOURCE_0 = 10'h336;

    // Reset values
    localparam logic [REG_W-1:0] RST_ZERO = 8'h00;
    localparam logic [REG_W-1:0] RST_LEVEL_SETTLE = 8'ha7;

    // Field positions
    localparam int BIT_STAY_RX = 0;
    localparam int BIT_STAY_TX = 1;
    localparam int BIT_EXT_AMP = 7;
    localparam int FAST_SEL_MSB = 2;
    localparam int STAT_PREAMBLE = 0;
    localparam int STAT_SFD = 1;
    localparam int STAT_CRC = 2;
    localparam int STAT_W = 3;
    localparam int IRQ_PREAMBLE = 0;
    localparam int IRQ_HEADER = 1;
    localparam int IRQ_CRC = 2;
    localparam int IRQ_TX_EOF = 3;
    localparam int IRQ_RX_EOF = 4;
    localparam int IRQ_WATERMARK = 5;
    localparam int IRQ_RING_FULL = 6;
    localparam int IRQ_ASSESS = 7;

    typedef enum logic [1:0] {
        PPC_BASE_IDLE = 2'b00,
        PPC_EXT_IDLE = 2'b01,
        PPC_EXT_TX = 2'b10,
        PPC_RX_ASSESS = 2'b11
    } ppc_state_t;

endpackage

// *** src/ppc_tx_ring.sv ***
// Transmit ring read pointer with wrap and watermark detection
`timescale 1ns/100ps
module ppc_tx_ring
    import ppc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic byte_sent,
    input wire logic [REG_W-1:0] ring_start,
    input wire logic [REG_W-1:0] ring_length,
    input wire logic [REG_W-1:0] watermark,
    output logic [REG_W-1:0] read_ptr,
    output logic ring_full,
    output logic watermark_hit
);

    logic [REG_W-1:0] offset;
    logic [REG_W-1:0] next_offset;
    logic at_end;
    logic at_mark;
    logic [REG_W-1:0] next_ptr;

    ////////////////////////////////////////////////////////////////////////////
    // Offset stepping
    assign at_end = byte_sent && (offset == ring_length);
    assign at_mark = byte_sent && (offset == watermark);
    assign next_offset = load ? RST_ZERO :
                         at_end ? RST_ZERO :
                         byte_sent ? REG_W'(offset + 8'h01) : offset;
    assign next_ptr = REG_W'(ring_start + next_offset);

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            offset <= RST_ZERO;
            read_ptr <= RST_ZERO;
            ring_full <= 1'b0;
            watermark_hit <= 1'b0;
        end else begin
            offset <= next_offset;
            read_ptr <= next_ptr;
            ring_full <= at_end && !load;
            watermark_hit <= at_mark && !load;
        end
    end

endmodule

// *** src/ppc_regs.sv ***
// APB register bank, radio state control and packet event logic
// Summary of operation
// - After sending byte at ring start plus length, flag ring full and wrap to start.
// - Stay-in-transmit set keeps transmit state after a packet, else extended idle.
// - Stay-in-receive set keeps receive state after a packet, else extended idle.
// - Synthesizer calibration stores the oscillator band result in its register.
// - Synthesizer calibration stores the oscillator amplitude result in its register.
// - Receive status reports CRC correct, delimiter seen and preamble seen bits.
// - Status bit 0 clear means no preamble seen on the current reception.
// - Mask bit 7 gates the channel assessment interrupt; busy flag gives result.
// - Mask bit 6 gates the ring full interrupt of either ring.
// - Mask bit 5 gates the ring watermark interrupt of either ring.
// - Mask bit 4 gates the receive packet complete interrupt.
// - Mask bit 3 gates the transmit packet complete interrupt.
// - Mask bit 2 gates the CRC correct interrupt.
// - Header interrupt armed by delimiter detection, issued when header reception ends.
// - Mask bit 0 gates the qualified preamble interrupt.
// - Each event sets its own source bit at the mask position; reset zero.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
module ppc_regs
    import ppc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmd_ext_idle,
    input wire logic cmd_base_idle,
    input wire logic cmd_tx,
    input wire logic cmd_rx,
    input wire logic tx_byte_sent,
    input wire logic tx_packet_done,
    input wire logic rx_packet_done,
    input wire logic rx_ring_full,
    input wire logic rx_ring_watermark,
    input wire logic preamble_detected,
    input wire logic frame_delimiter_seen,
    input wire logic header_done,
    input wire logic crc_ok,
    input wire logic assess_period_done,
    input wire logic channel_busy_flag,
    input wire logic synth_cal_done,
    input wire logic [REG_W-1:0] osc_band_result,
    input wire logic [REG_W-1:0] osc_amplitude_result,
    output ppc_state_t radio_state,
    output logic [REG_W-1:0] tx_read_ptr,
    output logic [REG_W-1:0] signal_level_settle_delay,
    output logic [FAST_SEL_MSB:0] fast_transition_sel,
    output logic external_amp_testbus_cfg,
    output logic irq
);

    logic [REG_W-1:0] irq_enable_0;
    logic [REG_W-1:0] irq_source_0;
    logic [REG_W-1:0] tx_ring_length;
    logic [REG_W-1:0] tx_ring_watermark;
    logic [REG_W-1:0] tx_ring_start;
    logic [REG_W-1:0] test_mode_ctrl;
    logic [REG_W-1:0] transition_speed;
    logic [REG_W-1:0] osc_band_cal;
    logic [REG_W-1:0] osc_amplitude_cal;
    logic [STAT_W-1:0] rx_frame_status;
    logic channel_busy_result;
    logic header_armed;
    ppc_state_t next_state;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode
    logic [IDX_W-1:0] idx;
    logic aligned;
    logic setup;
    logic wr_en;
    logic hit_status;
    logic hit_enable;
    logic hit_wmark;
    logic hit_length;
    logic hit_settle;
    logic hit_test;
    logic hit_speed;
    logic hit_band;
    logic hit_ampl;
    logic hit_start;
    logic hit_assess;
    logic hit_source;
    logic mapped;
    logic [REG_W-1:0] wbyte;
    logic [REG_W-1:0] rd_byte;

    assign idx = paddr[ADDR_W-1:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
    assign wbyte = pwdata[REG_W-1:0];
    assign hit_status = aligned && (idx == IDX_RX_FRAME_STATUS);
    assign hit_enable = aligned && (idx == IDX_IRQ_ENABLE_0);
    assign hit_wmark = aligned && (idx == IDX_TX_RING_WATERMARK);
    assign hit_length = aligned && (idx == IDX_TX_RING_LENGTH);
    assign hit_settle = aligned && (idx == IDX_LEVEL_SETTLE_DELAY);
    assign hit_test = aligned && (idx == IDX_TEST_MODE_CTRL);
    assign hit_speed = aligned && (idx == IDX_TRANSITION_SPEED);
    assign hit_band = aligned && (idx == IDX_OSC_BAND_CAL);
    assign hit_ampl = aligned && (idx == IDX_OSC_AMPLITUDE_CAL);
    assign hit_start = aligned && (idx == IDX_TX_RING_START);
    assign hit_assess = aligned && (idx == IDX_ASSESS_RESULT);
    assign hit_source = aligned && (idx == IDX_IRQ_SOURCE_0);
    assign mapped = hit_status | hit_enable | hit_wmark | hit_length | hit_settle | hit_test |
                    hit_speed | hit_band | hit_ampl | hit_start | hit_assess | hit_source;

    ////////////////////////////////////////////////////////////////////////////
    // Read selection
    assign rd_byte = ({REG_W{hit_status}} & {5'h00, rx_frame_status}) |
                     ({REG_W{hit_enable}} & irq_enable_0) |
                     ({REG_W{hit_wmark}} & tx_ring_watermark) |
                     ({REG_W{hit_length}} & tx_ring_length) |
                     ({REG_W{hit_settle}} & signal_level_settle_delay) |
                     ({REG_W{hit_test}} & test_mode_ctrl) |
                     ({REG_W{hit_speed}} & transition_speed) |
                     ({REG_W{hit_band}} & osc_band_cal) |
                     ({REG_W{hit_ampl}} & osc_amplitude_cal) |
                     ({REG_W{hit_start}} & tx_ring_start) |
                     ({REG_W{hit_assess}} & {7'h00, channel_busy_result}) |
                     ({REG_W{hit_source}} & irq_source_0);

    ////////////////////////////////////////////////////////////////////////////
    // APB answer, one access cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= setup;
            if (setup) begin
                pslverr <= !mapped;
                prdata <= {{(DATA_W-REG_W){1'b0}}, rd_byte};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enable_0 <= RST_ZERO;
            tx_ring_length <= RST_ZERO;
            tx_ring_watermark <= RST_ZERO;
            tx_ring_start <= RST_ZERO;
            signal_level_settle_delay <= RST_LEVEL_SETTLE;
            test_mode_ctrl <= RST_ZERO;
            transition_speed <= RST_ZERO;
        end else if (wr_en) begin
            if (hit_enable) begin
                irq_enable_0 <= wbyte;
            end
            if (hit_length) begin
                tx_ring_length <= wbyte;
            end
            if (hit_wmark) begin
                tx_ring_watermark <= wbyte;
            end
            if (hit_start) begin
                tx_ring_start <= wbyte;
            end
            if (hit_settle) begin
                signal_level_settle_delay <= wbyte;
            end
            if (hit_test) begin
                test_mode_ctrl <= wbyte;
            end
            if (hit_speed) begin
                transition_speed <= wbyte;
            end
        end
    end

    assign fast_transition_sel = transition_speed[FAST_SEL_MSB:0];
    assign external_amp_testbus_cfg = test_mode_ctrl[BIT_EXT_AMP];

    ////////////////////////////////////////////////////////////////////////////
    // Calibration results; a finishing calibration wins over a software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_band_cal <= RST_ZERO;
            osc_amplitude_cal <= RST_ZERO;
        end else if (synth_cal_done) begin
            osc_band_cal <= osc_band_result;
            osc_amplitude_cal <= osc_amplitude_result;
        end else if (wr_en) begin
            if (hit_band) begin
                osc_band_cal <= wbyte;
            end
            if (hit_ampl) begin
                osc_amplitude_cal <= wbyte;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Radio state
    always_comb begin
        next_state = radio_state;
        unique case (radio_state)
            PPC_BASE_IDLE: begin
                if (cmd_ext_idle) begin
                    next_state = PPC_EXT_IDLE;
                end
            end
            PPC_EXT_IDLE: begin
                if (cmd_base_idle) begin
                    next_state = PPC_BASE_IDLE;
                end else if (cmd_tx) begin
                    next_state = PPC_EXT_TX;
                end else if (cmd_rx) begin
                    next_state = PPC_RX_ASSESS;
                end
            end
            PPC_EXT_TX: begin
                if (cmd_ext_idle) begin
                    next_state = PPC_EXT_IDLE;
                end else if (tx_packet_done && !test_mode_ctrl[BIT_STAY_TX]) begin
                    next_state = PPC_EXT_IDLE;
                end
            end
            PPC_RX_ASSESS: begin
                if (cmd_ext_idle) begin
                    next_state = PPC_EXT_IDLE;
                end else if (rx_packet_done && !test_mode_ctrl[BIT_STAY_RX]) begin
                    next_state = PPC_EXT_IDLE;
                end
            end
        endcase
    end

    logic tx_enter;
    logic rx_enter;
    assign tx_enter = (next_state == PPC_EXT_TX) && (radio_state != PPC_EXT_TX);
    assign rx_enter = (next_state == PPC_RX_ASSESS) && (radio_state != PPC_RX_ASSESS);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            radio_state <= PPC_BASE_IDLE;
        end else begin
            radio_state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit ring
    logic tx_full_evt;
    logic tx_mark_evt;

    ppc_tx_ring u_tx_ring (
        .pclk(pclk),
        .presetn(presetn),
        .load(tx_enter),
        .byte_sent(tx_byte_sent && (radio_state == PPC_EXT_TX)),
        .ring_start(tx_ring_start),
        .ring_length(tx_ring_length),
        .watermark(tx_ring_watermark),
        .read_ptr(tx_read_ptr),
        .ring_full(tx_full_evt),
        .watermark_hit(tx_mark_evt)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Receive status and header arming
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_frame_status <= '0;
            header_armed <= 1'b0;
            channel_busy_result <= 1'b0;
        end else begin
            if (rx_enter) begin
                rx_frame_status <= '0;
                header_armed <= 1'b0;
            end else begin
                if (preamble_detected) begin
                    rx_frame_status[STAT_PREAMBLE] <= 1'b1;
                    rx_frame_status[STAT_SFD] <= 1'b0;
                    rx_frame_status[STAT_CRC] <= 1'b0;
                end
                if (frame_delimiter_seen) begin
                    rx_frame_status[STAT_SFD] <= 1'b1;
                end
                if (crc_ok) begin
                    rx_frame_status[STAT_CRC] <= 1'b1;
                end
                if (frame_delimiter_seen) begin
                    header_armed <= 1'b1;
                end else if (header_done) begin
                    header_armed <= 1'b0;
                end
            end
            if (assess_period_done) begin
                channel_busy_result <= channel_busy_flag;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt sources, write one to clear, a new event wins over the clear
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] src_clr;
    logic [EVT_W-1:0] next_source;

    assign evt[IRQ_ASSESS] = assess_period_done;
    assign evt[IRQ_RING_FULL] = tx_full_evt | rx_ring_full;
    assign evt[IRQ_WATERMARK] = tx_mark_evt | rx_ring_watermark;
    assign evt[IRQ_RX_EOF] = rx_packet_done;
    assign evt[IRQ_TX_EOF] = tx_packet_done;
    assign evt[IRQ_CRC] = crc_ok;
    assign evt[IRQ_HEADER] = header_done && header_armed;
    assign evt[IRQ_PREAMBLE] = preamble_detected;
    assign src_clr = (wr_en && hit_source) ? wbyte : RST_ZERO;

    genvar gi;
    generate
        for (gi = 0; gi < EVT_W; gi++) begin : g_src
            assign next_source[gi] = evt[gi] | (irq_source_0[gi] & ~src_clr[gi]);
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_source_0 <= RST_ZERO;
            irq <= 1'b0;
        end else begin
            irq_source_0 <= next_source;
            irq <= |(next_source & irq_enable_0);
        end
    end

endmodule

// *** dv/ppc_regs_monitor.sv ***
// Concurrent checks on the packet control and status register bank
`timescale 1ns/100ps
module ppc_regs_monitor
    import ppc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic cmd_ext_idle,
    input wire logic cmd_base_idle,
    input wire logic cmd_tx,
    input wire logic cmd_rx,
    input wire logic tx_byte_sent,
    input wire logic tx_packet_done,
    input wire logic rx_packet_done,
    input wire logic rx_ring_full,
    input wire logic rx_ring_watermark,
    input wire logic preamble_detected,
    input wire logic header_done,
    input wire logic crc_ok,
    input wire logic assess_period_done,
    input wire ppc_state_t radio_state,
    input wire logic [REG_W-1:0] tx_read_ptr,
    input wire logic irq
);
    logic [2:0] cause_q;
    logic [1:0] wr_q;
    wire no_cmd = !(cmd_ext_idle || cmd_base_idle || cmd_tx || cmd_rx);
    wire wr_acc = psel && penable && pwrite;
    wire any_evt = tx_byte_sent || tx_packet_done || rx_packet_done || rx_ring_full || rx_ring_watermark
        || preamble_detected || header_done || crc_ok || assess_period_done;
    wire in_tx = radio_state == PPC_EXT_TX;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_q <= 3'h0;
            wr_q <= 2'h0;
        end else begin
            cause_q <= {cause_q[1:0], any_evt || wr_acc};
            wr_q <= {wr_q[0], wr_acc};
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    ring_step_a:
        assert property (in_tx && $past(in_tx) && tx_byte_sent && no_cmd |=> tx_read_ptr != $past(tx_read_ptr))
        else $error("read pointer did not move on a sent byte");
    ring_hold_a:
        assert property (in_tx && $past(in_tx) && $past(in_tx, 2) && !tx_byte_sent && !$past(tx_byte_sent)
            && !psel && !$past(psel) && no_cmd |=> $stable(tx_read_ptr))
        else $error("read pointer moved without a sent byte");
    tx_stay_a:
        assert property (in_tx && tx_packet_done && no_cmd |=> radio_state inside {PPC_EXT_TX, PPC_EXT_IDLE})
        else $error("bad state after transmit end");
    tx_entry_a:
        assert property (radio_state == PPC_EXT_IDLE && cmd_tx && !cmd_base_idle && !cmd_ext_idle |=> in_tx)
        else $error("transmit command not taken");
    rx_stay_a:
        assert property (radio_state == PPC_RX_ASSESS && rx_packet_done && no_cmd
            |=> radio_state inside {PPC_RX_ASSESS, PPC_EXT_IDLE})
        else $error("bad state after receive end");
    irq_cause_a:
        assert property ($rose(irq) |-> |cause_q)
        else $error("interrupt rose without event or write");
    irq_fall_a:
        assert property ($fell(irq) |-> |wr_q)
        else $error("interrupt fell without a write");
    status_rsvd_a:
        assert property (psel && penable && !pwrite && paddr == 12'h07c |-> prdata[DATA_W-1:STAT_W] == '0)
        else $error("status reserved bits not zero");
    cover property (in_tx && tx_byte_sent);
    cover property ($rose(irq));
    cover property (radio_state == PPC_RX_ASSESS && rx_packet_done);
endmodule

bind ppc_regs ppc_regs_monitor mon (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .cmd_ext_idle, .cmd_base_idle, .cmd_tx,
    .cmd_rx, .tx_byte_sent, .tx_packet_done, .rx_packet_done, .rx_ring_full, .rx_ring_watermark,
    .preamble_detected, .header_done, .crc_ok, .assess_period_done, .radio_state, .tx_read_ptr, .irq
);

// *** dv/tb.sv ***
// Self-checking testbench for the packet control and status register bank
`timescale 1ns/100ps
module tb;
    import ppc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [3:0] pstrb = 4'hf;
    logic [15:0] ev = 16'h0;
    logic busy = 1'b0;
    logic [REG_W-1:0] band = 8'h00;
    logic [REG_W-1:0] ampl = 8'h00;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    ppc_state_t radio_state;
    logic [REG_W-1:0] tx_read_ptr;
    logic [REG_W-1:0] settle;
    logic [FAST_SEL_MSB:0] fast_sel;
    logic ext_amp;
    logic irq;
    int bad_count = 0;
    int n_checks = 0;
    always #2 pclk = ~pclk;
    ppc_regs uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmd_ext_idle(ev[12]), .cmd_base_idle(ev[13]), .cmd_tx(ev[14]), .cmd_rx(ev[15]),
        .tx_byte_sent(ev[9]), .tx_packet_done(ev[3]), .rx_packet_done(ev[4]), .rx_ring_full(ev[6]),
        .rx_ring_watermark(ev[5]), .preamble_detected(ev[0]), .frame_delimiter_seen(ev[8]),
        .header_done(ev[1]), .crc_ok(ev[2]), .assess_period_done(ev[7]), .channel_busy_flag(busy),
        .synth_cal_done(ev[10]), .osc_band_result(band), .osc_amplitude_result(ampl),
        .radio_state(radio_state), .tx_read_ptr(tx_read_ptr), .signal_level_settle_delay(settle),
        .fast_transition_sel(fast_sel), .external_amp_testbus_cfg(ext_amp), .irq(irq)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        cmp(r, exp, what);
        cmp(e, 1'b0, "slave error");
    endtask
    task automatic pulse(input int i);
        @(posedge pclk);
        ev[i] <= 1'b1;
        @(posedge pclk);
        ev[i] <= 1'b0;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [11:0] a[12] = '{12'h07c, 12'h400, 12'h4d8, 12'h4dc, 12'h4e0, 12'h4e4, 12'h4e8, 12'h4ec,
            12'h4f0, 12'h500, 12'h504, 12'hcd8};
        cmp(irq, 1'b0, "irq at reset");
        for (int i = 0; i < 12; i++) begin
            rd(a[i], (a[i] == 12'h4e0) ? 32'ha7 : 32'h0, "reset value");
        end
        $display("test reset done");
    endtask
    task automatic t_regs();
        logic [11:0] a[9] = '{12'h400, 12'h4d8, 12'h4dc, 12'h4e0, 12'h4e4, 12'h4e8, 12'h4ec, 12'h4f0, 12'h500};
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 9; i++) begin
            wr(a[i], {24'hffffff, 8'h31 + 8'(i)});
            rd(a[i], 32'h31 + i, "rw value");
        end
        wr(12'h4e4, 32'h80);
        cmp(ext_amp, 1'b1, "amp cfg");
        wr(12'h4e4, 32'h0);
        cmp(ext_amp, 1'b0, "amp cfg");
        wr(12'h4e8, 32'h1);
        cmp(fast_sel, 3'h1, "speed sel");
        pstrb <= 4'h0;
        wr(12'h4e8, 32'h5);
        pstrb <= 4'hf;
        rd(12'h4e8, 32'h1, "masked write");
        wr(12'h4e0, 32'h0);
        cmp(settle, 8'h00, "settle out");
        wr(12'h07c, 32'hff);
        rd(12'h07c, 32'h0, "ro write");
        apb(1'b0, 12'h004, 32'h0, r, e);
        cmp(e, 1'b1, "unmapped err");
        apb(1'b1, 12'h4e1, 32'hff, r, e);
        cmp(e, 1'b1, "misaligned err");
        rd(12'h4e0, 32'h0, "no write");
        wr(12'h4e0, 32'ha7);
        cmp(settle, 8'ha7, "settle restore");
        $display("test registers done");
    endtask
    task automatic t_ring();
        pulse(12);
        wr(12'h500, 32'h10);
        wr(12'h4dc, 32'h3);
        wr(12'h4d8, 32'h2);
        wr(12'h400, 32'h60);
        pulse(14);
        tick(2);
        cmp(tx_read_ptr, 8'h10, "ring start");
        for (int k = 1; k <= 4; k++) begin
            pulse(9);
            tick(1);
            cmp(tx_read_ptr, (k == 4) ? 8'h10 : 8'h10 + k, "ring ptr");
        end
        tick(2);
        cmp(irq, 1'b1, "ring irq");
        rd(12'hcd8, 32'h60, "ring source");
        wr(12'hcd8, 32'h60);
        tick(2);
        cmp(irq, 1'b0, "ring clear");
        pulse(12);
        $display("test ring done");
    endtask
    task automatic t_stay();
        for (int s = 0; s < 4; s++) begin
            wr(12'h4e4, s);
            pulse(12);
            pulse(14);
            tick(1);
            cmp(radio_state, PPC_EXT_TX, "tx entry");
            pulse(3);
            tick(1);
            cmp(radio_state, s[1] ? PPC_EXT_TX : PPC_EXT_IDLE, "after tx");
            pulse(12);
            pulse(15);
            tick(1);
            cmp(radio_state, PPC_RX_ASSESS, "rx entry");
            pulse(4);
            tick(1);
            cmp(radio_state, s[0] ? PPC_RX_ASSESS : PPC_EXT_IDLE, "after rx");
        end
        wr(12'hcd8, 32'hff);
        $display("test stay done");
    endtask
    task automatic t_events();
        wr(12'h4e4, 32'h1);
        pulse(12);
        pulse(15);
        for (int i = 0; i < 8; i++) begin
            wr(12'h400, 32'h1 << i);
            if (i == 1) pulse(8);
            pulse(i);
            tick(2);
            cmp(irq, 1'b1, "event irq");
            rd(12'hcd8, 32'h1 << i, "source bit");
            wr(12'hcd8, 32'h1 << i);
            tick(2);
            cmp(irq, 1'b0, "irq cleared");
        end
        wr(12'h400, 32'hfb);
        pulse(2);
        tick(2);
        cmp(irq, 1'b0, "masked irq");
        rd(12'hcd8, 32'h4, "masked source");
        wr(12'h400, 32'h4);
        tick(2);
        cmp(irq, 1'b1, "unmasked irq");
        wr(12'hcd8, 32'h4);
        pulse(1);
        rd(12'hcd8, 32'h0, "header unarmed");
        $display("test events done");
    endtask
    task automatic t_status();
        pulse(12);
        pulse(15);
        rd(12'h07c, 32'h0, "status entry");
        pulse(0);
        rd(12'h07c, 32'h1, "preamble");
        pulse(8);
        rd(12'h07c, 32'h3, "delimiter");
        pulse(2);
        rd(12'h07c, 32'h7, "crc");
        pulse(0);
        rd(12'h07c, 32'h1, "new packet");
        busy <= 1'b1;
        pulse(7);
        rd(12'h504, 32'h1, "busy flag");
        busy <= 1'b0;
        band <= 8'h5a;
        ampl <= 8'hc3;
        pulse(10);
        rd(12'h4ec, 32'h5a, "band cal");
        rd(12'h4f0, 32'hc3, "amp cal");
        wr(12'hcd8, 32'hff);
        $display("test status done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_regs();
        t_ring();
        t_stay();
        t_events();
        t_status();
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        cmp(1'b0, 1'b1, "timeout");
        complete_run();
    end
endmodule
